// File: pkg/ltc_pkg.sv
// Package for the transmit path configuration bank: offsets, fields, resets, codes.
// Assumes a host control port with byte-wide data and a byte address.
package ltc_pkg;

	// Register offsets on the control port.
	localparam logic [7:0] LTC_OFS_CFG0 = 8'h05;
	localparam logic [7:0] LTC_OFS_CFG1 = 8'h06;
	localparam logic [7:0] LTC_OFS_CFG2 = 8'h07;
	localparam logic [7:0] LTC_OFS_CFG3 = 8'h08;
	localparam logic [7:0] LTC_OFS_CFG4 = 8'h09;

	// Field positions.
	localparam int LTC_BIT_POWER_DOWN = 4;
	localparam int LTC_BIT_INVERT = 3;
	localparam int LTC_BIT_EDGE = 2;
	localparam int LTC_BIT_MONITOR_OFF = 5;
	localparam int LTC_BIT_TRISTATE = 4;
	localparam int LTC_BIT_ACCESS_GO = 7;
	localparam int LTC_BIT_ACCESS_READ = 6;

	// Values after reset.
	localparam logic [7:0] LTC_RST_CFG0 = 8'h00;
	localparam logic [7:0] LTC_RST_CFG1 = 8'h10;
	localparam logic [7:0] LTC_RST_CFG2 = 8'h21;
	localparam logic [7:0] LTC_RST_CFG3 = 8'h00;
	localparam logic [6:0] LTC_RST_SAMPLE = 7'h00;

	// Template codes and gain figures.
	localparam logic [3:0] LTC_TPL_E1_75 = 4'h0;
	localparam logic [3:0] LTC_TPL_E1_120 = 4'h1;
	localparam logic [3:0] LTC_TPL_DSX1_FIRST = 4'h2;
	localparam logic [3:0] LTC_TPL_DSX1_LAST = 4'h6;
	localparam logic [3:0] LTC_TPL_J1 = 4'h7;
	localparam logic [5:0] LTC_GAIN_T1 = 6'h36;
	localparam logic [5:0] LTC_GAIN_E1 = 6'h21;
	localparam logic [7:0] LTC_STEP_T1_PCT = 8'h02;
	localparam logic [7:0] LTC_STEP_E1_PCT = 8'h03;

	// Template memory shape.
	localparam int LTC_UI_COUNT = 4;
	localparam int LTC_SAMPLES_PER_UI = 16;

	// Encoder selection derived from the two-bit mode field.
	typedef enum logic [1:0] {
		LTC_ENC_HDB3 = 2'b00,
		LTC_ENC_AMI = 2'b01,
		LTC_ENC_BYPASS = 2'b10
	} ltc_enc_t;

	// Template class for the shaper.
	typedef enum logic [2:0] {
		LTC_CLS_E1_75 = 3'b000,
		LTC_CLS_E1_120 = 3'b001,
		LTC_CLS_DSX1 = 3'b010,
		LTC_CLS_J1 = 3'b011,
		LTC_CLS_RESERVED = 3'b100,
		LTC_CLS_USER = 3'b101
	} ltc_cls_t;

	// Settings handed to the transmit datapath.
	typedef struct packed {
		logic power_down;
		logic polarity_invert;
		logic sample_rising;
		ltc_enc_t encoder;
		logic monitor_disable;
		logic tristate;
		logic [3:0] template_code;
		logic [5:0] gain_code;
	} ltc_cfg_t;

	// Host write or read request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ltc_req_t;

endpackage : ltc_pkg

// File: core/ltc_template_ram.sv
// Waveform template memory: four unit intervals of sixteen amplitude samples.
// Assumes one access at a time requested by the register bank on the same clock.
`timescale 1ns/1ps
module ltc_template_ram import ltc_pkg::*; #(
	parameter int UI_COUNT = LTC_UI_COUNT,
	parameter int SAMPLES = LTC_SAMPLES_PER_UI,
	parameter int WIDTH = 7
) (
	// Clocking.
	input wire logic clk,
	input wire logic clk_en,
	// Host access.
	input wire logic access_go,
	input wire logic access_read,
	input wire logic [1:0] unit_interval_index,
	input wire logic [3:0] point_index_in_interval,
	input wire logic [WIDTH-1:0] template_amplitude_word,
	output logic [WIDTH-1:0] read_word,
	// Shaper playback port.
	input wire logic [5:0] play_addr,
	output logic [WIDTH-1:0] play_word
);

	logic [WIDTH-1:0] mem [UI_COUNT*SAMPLES];
	logic [5:0] addr;

	assign addr = {unit_interval_index, point_index_in_interval};

	// Memory has no reset; software loads it before selecting a user template.
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (access_go && !access_read) begin
				mem[addr] <= template_amplitude_word;
			end
			if (access_go && access_read) begin
				read_word <= mem[addr];
			end
			play_word <= mem[play_addr];
		end
	end

endmodule : ltc_template_ram

// File: core/ltc_tx_encoder.sv
// Transmit rail encoder: HDB3/B8ZS, AMI or dual-rail bypass; polarity inversion is applied before it.
// Assumes rail inputs are already synchronised and edge-selected.
`timescale 1ns/1ps
module ltc_tx_encoder import ltc_pkg::*; (
	// Clocking.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Configuration.
	input wire logic t1_mode,
	input wire ltc_enc_t encoder,
	// Data in and out.
	input wire logic bit_in,
	input wire logic pos_in,
	input wire logic neg_in,
	output logic pos_out,
	output logic neg_out
);

	logic last_mark_q;
	logic [2:0] zero_run_q;

	// Zero substitution is a simplified run-length form; a full lookahead would add delay.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_out <= 1'b0;
			neg_out <= 1'b0;
			last_mark_q <= 1'b0;
			zero_run_q <= 3'h0;
		end else if (clk_en) begin
			if (encoder == LTC_ENC_BYPASS) begin
				pos_out <= pos_in;
				neg_out <= neg_in;
			end else if (bit_in) begin
				pos_out <= !last_mark_q;
				neg_out <= last_mark_q;
				last_mark_q <= !last_mark_q;
				zero_run_q <= 3'h0;
			end else if (encoder == LTC_ENC_HDB3 &&
				zero_run_q == (t1_mode ? 3'h7 : 3'h3)) begin
				// Violation pulse repeats the previous polarity.
				pos_out <= last_mark_q;
				neg_out <= !last_mark_q;
				zero_run_q <= 3'h0;
			end else begin
				pos_out <= 1'b0;
				neg_out <= 1'b0;
				zero_run_q <= zero_run_q + 3'h1;
			end
		end
	end

endmodule : ltc_tx_encoder

// File: core/ltc_tx_config.sv
// Transmit path configuration bank with rail input stage and line driver control.
// Assumes a synchronous byte-wide host port on clk, which is the transmit clock.
`timescale 1ns/1ps
module ltc_tx_config import ltc_pkg::*; #(
	parameter int DATA_W = 8
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	// Global mode from the rest of the device.
	input wire logic t1_mode,
	// Host register port.
	input wire ltc_req_t host_req,
	output logic [DATA_W-1:0] host_rdata,
	output logic host_rvalid,
	// Transmit data pins.
	input wire logic transmit_single_rail_in,
	input wire logic transmit_pos_rail_in,
	input wire logic transmit_neg_rail_in,
	// Driver status from the analog side.
	input wire logic driver_fault_raw,
	// Line side.
	output logic line_pos_q,
	output logic line_neg_q,
	output logic line_drive_en_q,
	output logic transmitter_power_q,
	output logic driver_fault_monitor_q,
	output ltc_cls_t template_class_q,
	output logic [5:0] amplitude_gain_code_q,
	output logic [7:0] gain_step_pct_q,
	output logic [6:0] shaper_sample_q
);

	logic [7:0] transmit_config_0_q;
	logic [7:0] transmit_config_1_q;
	logic [7:0] transmit_config_2_q;
	logic [7:0] access_ctrl_q;
	logic [6:0] template_amplitude_word_q;
	logic access_go_q;
	logic access_read_done_q;
	ltc_cfg_t cfg;
	logic [6:0] ram_rdata;
	logic [6:0] ram_play;
	logic [5:0] play_addr_q;
	logic [1:0] single_sync_q;
	logic [1:0] pos_sync_q;
	logic [1:0] neg_sync_q;
	logic [1:0] fault_sync_q;
	logic pos_fall_q;
	logic neg_fall_q;
	logic bit_in;
	logic pos_in;
	logic neg_in;
	logic enc_pos;
	logic enc_neg;

	// Maps a template code to the shaper class.
	function automatic ltc_cls_t classify(input logic [3:0] code);
		ltc_cls_t cls;
		cls = LTC_CLS_RESERVED;
		if (code == LTC_TPL_E1_75) begin
			cls = LTC_CLS_E1_75;
		end else if (code == LTC_TPL_E1_120) begin
			cls = LTC_CLS_E1_120;
		end else if (code >= LTC_TPL_DSX1_FIRST && code <= LTC_TPL_DSX1_LAST) begin
			cls = LTC_CLS_DSX1;
		end else if (code == LTC_TPL_J1) begin
			cls = LTC_CLS_J1;
		end else if (code[3:2] == 2'b11) begin
			cls = LTC_CLS_USER;
		end
		return cls;
	endfunction : classify

	// Decodes whether an address is one of this bank's registers.
	function automatic logic mapped(input logic [7:0] addr);
		return addr >= LTC_OFS_CFG0 && addr <= LTC_OFS_CFG4;
	endfunction : mapped

	// Register writes; stored fields take effect on the next clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			transmit_config_0_q <= LTC_RST_CFG0;
			transmit_config_1_q <= LTC_RST_CFG1;
			transmit_config_2_q <= LTC_RST_CFG2;
			access_ctrl_q <= LTC_RST_CFG3;
			template_amplitude_word_q <= LTC_RST_SAMPLE;
		end else if (clk_en && host_req.wr && mapped(host_req.addr)) begin
			if (host_req.addr == LTC_OFS_CFG0) begin
				transmit_config_0_q <= host_req.wdata;
			end else if (host_req.addr == LTC_OFS_CFG1) begin
				transmit_config_1_q <= host_req.wdata;
			end else if (host_req.addr == LTC_OFS_CFG2) begin
				transmit_config_2_q <= host_req.wdata;
			end else if (host_req.addr == LTC_OFS_CFG3) begin
				// The trigger bit is self-clearing; it reads back as zero.
				access_ctrl_q <= {1'b0, host_req.wdata[6:0]};
			end else begin
				template_amplitude_word_q <= host_req.wdata[6:0];
			end
		end else if (clk_en && access_read_done_q) begin
			// Any host write to a mapped register wins over a read completing with it; the read data is dropped.
			template_amplitude_word_q <= ram_rdata;
		end
	end

	// One-cycle access strobe on a trigger write.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			access_go_q <= 1'b0;
		end else if (clk_en) begin
			access_go_q <= host_req.wr && host_req.addr == LTC_OFS_CFG3 &&
				host_req.wdata[LTC_BIT_ACCESS_GO];
		end
	end

	// Read completion one clock after the strobe, once the memory output holds the sample.
	// Taking the data at the strobe edge itself would load the previous read.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			access_read_done_q <= 1'b0;
		end else if (clk_en) begin
			access_read_done_q <= access_go_q && access_ctrl_q[LTC_BIT_ACCESS_READ];
		end
	end

	// Read data one cycle after the request; unmapped addresses read zero.
	// A read in the same cycle as a write to that register returns the old value.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			host_rdata <= 8'h00;
			host_rvalid <= 1'b0;
		end else if (clk_en) begin
			host_rvalid <= host_req.rd;
			if (!host_req.rd) begin
				host_rdata <= 8'h00;
			end else if (host_req.addr == LTC_OFS_CFG0) begin
				host_rdata <= transmit_config_0_q;
			end else if (host_req.addr == LTC_OFS_CFG1) begin
				host_rdata <= transmit_config_1_q;
			end else if (host_req.addr == LTC_OFS_CFG2) begin
				host_rdata <= transmit_config_2_q;
			end else if (host_req.addr == LTC_OFS_CFG3) begin
				host_rdata <= access_ctrl_q;
			end else if (host_req.addr == LTC_OFS_CFG4) begin
				host_rdata <= {1'b0, template_amplitude_word_q};
			end else begin
				host_rdata <= 8'h00;
			end
		end
	end

	// Field unpacking into the datapath settings.
	always_comb begin
		cfg.power_down = transmit_config_0_q[LTC_BIT_POWER_DOWN];
		cfg.polarity_invert = transmit_config_0_q[LTC_BIT_INVERT];
		cfg.sample_rising = transmit_config_0_q[LTC_BIT_EDGE];
		cfg.encoder = transmit_config_0_q[1] ? LTC_ENC_BYPASS : ltc_enc_t'(transmit_config_0_q[1:0]);
		cfg.monitor_disable = transmit_config_1_q[LTC_BIT_MONITOR_OFF];
		cfg.tristate = transmit_config_1_q[LTC_BIT_TRISTATE];
		cfg.template_code = transmit_config_1_q[3:0];
		cfg.gain_code = transmit_config_2_q[5:0];
	end

	// Two-flop synchronisers for pin inputs.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			single_sync_q <= 2'b00;
			pos_sync_q <= 2'b00;
			neg_sync_q <= 2'b00;
			fault_sync_q <= 2'b00;
		end else if (clk_en) begin
			single_sync_q <= {single_sync_q[0], transmit_single_rail_in};
			pos_sync_q <= {pos_sync_q[0], transmit_pos_rail_in};
			neg_sync_q <= {neg_sync_q[0], transmit_neg_rail_in};
			fault_sync_q <= {fault_sync_q[0], driver_fault_raw};
		end
	end

	// Falling-edge capture of synchronised rails, for the falling-edge option.
	// It leaves half a period to the encoder; that is the price of keeping one clock.
	always_ff @(negedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_fall_q <= 1'b0;
			neg_fall_q <= 1'b0;
		end else if (clk_en) begin
			pos_fall_q <= pos_sync_q[1];
			neg_fall_q <= neg_sync_q[1];
		end
	end

	// Edge choice and polarity applied before the encoder.
	always_comb begin
		bit_in = single_sync_q[1] ^ cfg.polarity_invert;
		pos_in = (cfg.sample_rising ? pos_sync_q[1] : pos_fall_q) ^ cfg.polarity_invert;
		neg_in = (cfg.sample_rising ? neg_sync_q[1] : neg_fall_q) ^ cfg.polarity_invert;
	end

	ltc_tx_encoder u_encoder (
		.clk(clk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.t1_mode(t1_mode),
		.encoder(cfg.encoder),
		.bit_in(bit_in),
		.pos_in(pos_in),
		.neg_in(neg_in),
		.pos_out(enc_pos),
		.neg_out(enc_neg)
	);

	ltc_template_ram u_template (
		.clk(clk),
		.clk_en(clk_en),
		.access_go(access_go_q),
		.access_read(access_ctrl_q[LTC_BIT_ACCESS_READ]),
		.unit_interval_index(access_ctrl_q[5:4]),
		.point_index_in_interval(access_ctrl_q[3:0]),
		.template_amplitude_word(template_amplitude_word_q),
		.read_word(ram_rdata),
		.play_addr(play_addr_q),
		.play_word(ram_play)
	);

	// Line outputs registered so a setting change never glitches the pins.
	// The enable is kept apart from the rails so a floated driver still sees live data.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			line_pos_q <= 1'b0;
			line_neg_q <= 1'b0;
			line_drive_en_q <= 1'b0;
			transmitter_power_q <= 1'b0;
		end else if (clk_en) begin
			line_pos_q <= enc_pos && !cfg.power_down;
			line_neg_q <= enc_neg && !cfg.power_down;
			transmitter_power_q <= !cfg.power_down;
			line_drive_en_q <= !cfg.power_down && !cfg.tristate;
		end
	end

	// Fault monitor gated by its disable bit.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			driver_fault_monitor_q <= 1'b0;
		end else if (clk_en) begin
			driver_fault_monitor_q <= fault_sync_q[1] && !cfg.monitor_disable;
		end
	end

	// Template class, gain and step size for the shaper.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			template_class_q <= LTC_CLS_E1_75;
			amplitude_gain_code_q <= LTC_GAIN_E1;
			gain_step_pct_q <= LTC_STEP_E1_PCT;
		end else if (clk_en) begin
			template_class_q <= classify(cfg.template_code);
			amplitude_gain_code_q <= cfg.gain_code;
			// T1/J1 uses two percent per step, E1 three.
			gain_step_pct_q <= t1_mode ? LTC_STEP_T1_PCT : LTC_STEP_E1_PCT;
		end
	end

	// User waveform playback walks all sixty-four samples while a user code is set.
	// The memory has no reset, so the stream is unknown until software loads it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			play_addr_q <= 6'h00;
			shaper_sample_q <= 7'h00;
		end else if (clk_en) begin
			if (classify(cfg.template_code) == LTC_CLS_USER) begin
				play_addr_q <= play_addr_q + 6'h01;
				shaper_sample_q <= ram_play;
			end else begin
				play_addr_q <= 6'h00;
				shaper_sample_q <= 7'h00;
			end
		end
	end

endmodule : ltc_tx_config

// File: sim/ltc_tx_config_props.sv
// Port checker for the transmit configuration bank.
// Assumes it is bound to the top module; all of it runs on clk.
`timescale 1ns/1ps
module ltc_tx_config_props import ltc_pkg::*; (
	// Clock, reset and global inputs.
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic t1_mode,
	// Host port.
	input wire ltc_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid,
	// Line side.
	input wire logic line_pos_q,
	input wire logic line_neg_q,
	input wire logic line_drive_en_q,
	input wire logic transmitter_power_q,
	input wire ltc_cls_t template_class_q,
	input wire logic [5:0] amplitude_gain_code_q,
	input wire logic [7:0] gain_step_pct_q
);
	// Everything is sampled on the rising edge and silenced in reset.
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_read_answer: assert property (host_req.rd && clk_en |=> host_rvalid)
		else $error("read request got no answer");
	chk_answer_cause: assert property (host_rvalid |-> $past(host_req.rd))
		else $error("read answer without request");
	chk_idle_rdata: assert property (!host_rvalid |-> host_rdata == 8'h00)
		else $error("read data not cleared");
	chk_off_quiet: assert property (!transmitter_power_q && !$past(transmitter_power_q) |->
		!line_drive_en_q && !line_pos_q && !line_neg_q)
		else $error("line active in power down");
	chk_drive_power: assert property (line_drive_en_q |-> transmitter_power_q)
		else $error("driver on while powered down");
	chk_power_write: assert property (host_req.wr && host_req.addr == LTC_OFS_CFG0 |->
		##2 transmitter_power_q == !$past(host_req.wdata[LTC_BIT_POWER_DOWN], 2))
		else $error("power bit not applied");
	chk_gain_write: assert property ((host_req.wr && host_req.addr == LTC_OFS_CFG2) ##2 1 |->
		amplitude_gain_code_q == $past(host_req.wdata[5:0], 2))
		else $error("gain field not applied");
	chk_step_size: assert property ($past(clk_en) |->
		gain_step_pct_q == ($past(t1_mode) ? LTC_STEP_T1_PCT : LTC_STEP_E1_PCT))
		else $error("wrong gain step");

	// Main scenarios that the bench should reach.
	cov_read: cover property (host_rvalid);
	cov_power_back: cover property (!transmitter_power_q ##1 transmitter_power_q);
	cov_user: cover property (template_class_q == LTC_CLS_USER);
endmodule : ltc_tx_config_props

bind ltc_tx_config ltc_tx_config_props ltc_tx_config_props_inst (.clk(clk), .arst_n(arst_n),
	.clk_en(clk_en), .t1_mode(t1_mode), .host_req(host_req), .host_rdata(host_rdata),
	.host_rvalid(host_rvalid), .line_pos_q(line_pos_q), .line_neg_q(line_neg_q),
	.line_drive_en_q(line_drive_en_q), .transmitter_power_q(transmitter_power_q),
	.template_class_q(template_class_q), .amplitude_gain_code_q(amplitude_gain_code_q),
	.gain_step_pct_q(gain_step_pct_q));

// File: sim/ltc_host_model.sv
// Host processor model for the byte-wide register port.
// Assumes a read answer arrives one clock after the request.
`timescale 1ns/1ps
module ltc_host_model import ltc_pkg::*; (
	// Clock.
	input wire logic clk,
	// Register port.
	output ltc_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid
);
	initial host_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

	// One request held for one cycle; afterwards address and data are scrambled,
	// so a bank that samples late sees garbage rather than a lucky old value.
	task automatic issue(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 host_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		#1 host_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask : issue

	// The two upper bits of the tristate register are always sent as zero.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		issue(1'b1, a, (a == LTC_OFS_CFG1) ? (d & 8'h3f) : d);
	endtask : write_reg

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
		issue(1'b0, a, 8'h00);
		d = host_rdata;
		v = host_rvalid;
	endtask : read_reg
endmodule : ltc_host_model

// File: sim/ltc_tx_config_bench.sv
// Self-checking bench for the transmit configuration bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module ltc_tx_config_bench import ltc_pkg::*; ;
	logic clk = 1'b0, arst_n = 1'b0, t1_mode = 1'b0, fault_raw = 1'b0;
	logic srail = 1'b0, prail = 1'b0, nrail = 1'b0, rd_ok;
	ltc_req_t host_req;
	logic [7:0] host_rdata, rd_val, step_q;
	logic host_rvalid, pos_q, neg_q, drive_q, power_q, mon_q;
	ltc_cls_t class_q;
	logic [5:0] gain_q;
	logic [6:0] sample_q;
	int err_count = 0, checked = 0, cycles = 0, pos_n, neg_n;

	// Clock of 20 ns period.
	always #10 clk = ~clk;

	ltc_tx_config ltc_tx_config_inst (.clk(clk), .arst_n(arst_n), .clk_en(1'b1),
		.t1_mode(t1_mode), .host_req(host_req), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .transmit_single_rail_in(srail),
		.transmit_pos_rail_in(prail), .transmit_neg_rail_in(nrail),
		.driver_fault_raw(fault_raw), .line_pos_q(pos_q), .line_neg_q(neg_q),
		.line_drive_en_q(drive_q), .transmitter_power_q(power_q),
		.driver_fault_monitor_q(mon_q), .template_class_q(class_q),
		.amplitude_gain_code_q(gain_q), .gain_step_pct_q(step_q), .shaper_sample_q(sample_q));
	ltc_host_model ltc_host_model_inst (.clk(clk), .host_req(host_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid));

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	// Writes wait three clocks, enough for a template access to finish as well.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ltc_host_model_inst.write_reg(a, d);
		settle(3);
	endtask : wr

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		ltc_host_model_inst.read_reg(a, rd_val, rd_ok);
		cmp_bit(rd_ok, 1'b1);
		cmp_byte(rd_val, exp);
	endtask : chk_reg

	// Sets the pins and mode, lets the pipeline fill, then counts marks per rail.
	task automatic rails(input logic [7:0] cfg, input logic s, p, n, input int ep, en);
		{srail, prail, nrail} = {s, p, n};
		wr(LTC_OFS_CFG0, cfg);
		settle(8);
		pos_n = 0;
		neg_n = 0;
		repeat (16) begin
			if (pos_q === 1'b1) pos_n++;
			if (neg_q === 1'b1) neg_n++;
			settle(1);
		end
		if (ep >= 0) begin
			cmp_byte(8'(pos_n), 8'(ep));
			cmp_byte(8'(neg_n), 8'(en));
		end
	endtask : rails

	function automatic ltc_cls_t cls_of(input logic [3:0] c);
		case (c) inside
			4'h0: return LTC_CLS_E1_75;
			4'h1: return LTC_CLS_E1_120;
			[4'h2:4'h6]: return LTC_CLS_DSX1;
			4'h7: return LTC_CLS_J1;
			[4'h8:4'hb]: return LTC_CLS_RESERVED;
			default: return LTC_CLS_USER;
		endcase
	endfunction : cls_of

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// Cuts a hung run short; the whole sequence needs well under 3000 cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("ERROR %0t run too long", $time);
			complete_run();
		end
	end

	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		#1 arst_n = 1'b1;
		settle(2);
		cmp_bit(drive_q, 1'b0);
		cmp_bit(power_q, 1'b1);
		cmp_byte({2'b00, gain_q}, 8'h21);
		cmp_byte(step_q, 8'h03);
		cmp_byte({1'b0, sample_q}, 8'h00);
		chk_reg(LTC_OFS_CFG0, 8'h00);
		chk_reg(LTC_OFS_CFG1, 8'h10);
		chk_reg(LTC_OFS_CFG2, 8'h21);
		chk_reg(8'h30, 8'h00);
		for (int c = 0; c < 16; c++) begin
			if (c inside {[8:11]}) continue;
			wr(LTC_OFS_CFG1, 8'(c));
			cmp_byte({5'h00, class_q}, {5'h00, cls_of(4'(c))});
		end
		cmp_bit(drive_q, 1'b1);
		fault_raw = 1'b1;
		settle(6);
		cmp_bit(mon_q, 1'b1);
		wr(LTC_OFS_CFG1, 8'h20);
		cmp_bit(mon_q, 1'b0);
		wr(LTC_OFS_CFG2, 8'h36);
		cmp_byte({2'b00, gain_q}, 8'h36);
		t1_mode = 1'b1;
		settle(2);
		cmp_byte(step_q, 8'h02);
		t1_mode = 1'b0;
		settle(2);
		cmp_byte(step_q, 8'h03);
		rails(8'h06, 1'b0, 1'b1, 1'b0, 16, 0);
		rails(8'h0a, 1'b0, 1'b1, 1'b0, 0, 16);
		rails(8'h01, 1'b1, 1'b0, 1'b0, 8, 8);
		rails(8'h09, 1'b1, 1'b0, 1'b0, 0, 0);
		rails(8'h01, 1'b0, 1'b0, 1'b0, 0, 0);
		rails(8'h00, 1'b0, 1'b0, 1'b0, -1, 0);
		cmp_bit(pos_n + neg_n > 0, 1'b1);
		cmp_bit(pos_n == 0 || neg_n == 0, 1'b1);
		rails(8'h11, 1'b1, 1'b0, 1'b0, 0, 0);
		cmp_bit(drive_q, 1'b0);
		cmp_bit(power_q, 1'b0);
		wr(LTC_OFS_CFG1, 8'h10);
		rails(8'h01, 1'b1, 1'b0, 1'b0, 8, 8);
		cmp_bit(drive_q, 1'b0);
		wr(LTC_OFS_CFG4, 8'h55);
		wr(LTC_OFS_CFG3, 8'hbf);
		wr(LTC_OFS_CFG4, 8'h00);
		wr(LTC_OFS_CFG3, 8'hff);
		chk_reg(LTC_OFS_CFG4, 8'h55);
		chk_reg(LTC_OFS_CFG3, 8'h7f);
		// A user code plays the whole memory; only the one loaded sample is known.
		wr(LTC_OFS_CFG1, 8'h1c);
		pos_n = 0;
		repeat (64) begin
			if (sample_q === 7'h55) pos_n++;
			settle(1);
		end
		cmp_byte(8'(pos_n), 8'h01);
		complete_run();
	end
endmodule : ltc_tx_config_bench
